//--- hw/pcm_pkg.sv
// Purpose: shared constants and types of the cpu power mode control block
// Assumes: apb register map with 32-bit aligned words
// Notes: request bits and flags sit in the power control register
package pcm_pkg;

    // register byte offsets
    localparam logic [7:0] PCM_OFS_POWER_CONTROL = 8'h00;
    localparam logic [7:0] PCM_OFS_CLOCK_CONFIG = 8'h04;
    localparam logic [7:0] PCM_OFS_STATUS = 8'h08;

    // power control register fields
    localparam int PCM_BIT_IDLE_REQUEST = 0;
    localparam int PCM_BIT_SLEEP_REQUEST = 1;
    localparam int PCM_BIT_USER_FLAG_ZERO = 2;
    localparam int PCM_BIT_USER_FLAG_ONE = 3;
    localparam int PCM_POWER_CONTROL_WIDTH = 4;

    // clock config register fields
    localparam int PCM_BIT_CLOCK_HALVING = 0;

    // status register fields
    localparam int PCM_STATUS_MODE_LSB = 0;
    localparam int PCM_STATUS_MODE_WIDTH = 4;
    localparam int PCM_BIT_STATUS_RAM_BLOCK = 4;

    // reset values
    localparam logic [3:0] PCM_RST_POWER_CONTROL = 4'h0;
    localparam logic PCM_RST_CLOCK_HALVING = 1'b0;

    // synchroniser stages and line count
    localparam int PCM_SYNC_STAGES = 2;
    localparam int PCM_SYNC_LINES = 3;
    localparam int PCM_LINE_RESET_PIN = 0;
    localparam int PCM_LINE_IRQ_ZERO = 1;
    localparam int PCM_LINE_IRQ_ONE = 2;

    // operating modes, one-hot
    typedef enum logic [3:0] {
        PCM_RUN = 4'h1,
        PCM_IDLE = 4'h2,
        PCM_SLEEP = 4'h4,
        PCM_HOLD = 4'h8
    } pcm_mode_t;

endpackage

//--- hw/pcm_sync_if.sv
// Purpose: carries raw pin levels to the synchroniser and clean levels back
// Assumes: one clock, pclk
// Notes: width set by the instantiating module
`timescale 1ns/1ps
interface pcm_sync_if #(
    parameter int WIDTH = 3
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    // synchroniser side and user side
    modport sync_side (input raw, output synced);
    modport user (output raw, input synced);
endinterface

//--- hw/pcm_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are slow levels, not single-cycle pulses
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pcm_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    pcm_sync_if.sync_side port
);

    // one synchroniser per line
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_line
            logic meta;
            logic stable;
            // two stages, reset to the idle level of the line
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta <= RESET_VALUE[g];
                    stable <= RESET_VALUE[g];
                end else begin
                    meta <= port.raw[g];
                    stable <= meta;
                end
            end
            assign port.synced[g] = stable;
        end
    endgenerate

endmodule

//--- hw/pcm_power_ctrl.sv
// Purpose: idle and sleep mode control with clock gating enables
// Assumes: cpu pulses instr_done at the end of each instruction
// Notes: reset_pin high clears both request bits without a clock edge
`timescale 1ns/1ps

module pcm_power_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic ext_irq_zero_n,
    input wire logic ext_irq_one_n,
    input wire logic ext_irq_zero_en,
    input wire logic ext_irq_one_en,
    input wire logic reset_pin,
    input wire logic core_reset_active,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_enable,
    output logic cpu_hold,
    output logic clock_halving_mode,
    output logic ram_block
);

    // request side reset: power-on reset or reset pin high
    logic req_rst_n;
    assign req_rst_n = presetn & ~reset_pin;

    // pin synchronisers
    pcm_sync_if #(.WIDTH(pcm_pkg::PCM_SYNC_LINES)) sync_port ();
    assign sync_port.raw = {ext_irq_one_n, ext_irq_zero_n, reset_pin};

    pcm_sync #(
        .WIDTH(pcm_pkg::PCM_SYNC_LINES),
        .RESET_VALUE(3'h6)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .port(sync_port.sync_side)
    );

    // clean pin levels
    logic rst_pin_s;
    logic irq_zero_low;
    logic irq_one_low;
    assign rst_pin_s = sync_port.synced[pcm_pkg::PCM_LINE_RESET_PIN];
    assign irq_zero_low = ~sync_port.synced[pcm_pkg::PCM_LINE_IRQ_ZERO];
    assign irq_one_low = ~sync_port.synced[pcm_pkg::PCM_LINE_IRQ_ONE];

    // external wake request and its release
    logic ext_wake;
    logic ext_level_low;
    assign ext_wake = (irq_zero_low & ext_irq_zero_en) | (irq_one_low & ext_irq_one_en);
    assign ext_level_low = irq_zero_low | irq_one_low;

    // register state
    pcm_pkg::pcm_mode_t mode;
    pcm_pkg::pcm_mode_t next_mode;
    logic idle_request_bit;
    logic sleep_request_bit;
    logic user_flag_zero;
    logic user_flag_one;
    logic next_idle_request_bit;
    logic next_sleep_request_bit;
    logic lowpower_seen;
    logic next_lowpower_seen;
    logic next_ram_block;

    // apb decode
    logic setup_phase;
    logic access_done;
    logic hit_power;
    logic hit_clock;
    logic hit_status;
    logic addr_mapped;
    logic wr_power;
    logic wr_clock;
    assign setup_phase = psel & ~penable & ~pready;
    assign access_done = psel & penable & pready;
    assign hit_power = (paddr == pcm_pkg::PCM_OFS_POWER_CONTROL);
    assign hit_clock = (paddr == pcm_pkg::PCM_OFS_CLOCK_CONFIG);
    assign hit_status = (paddr == pcm_pkg::PCM_OFS_STATUS);
    assign addr_mapped = hit_power | hit_clock | hit_status;
    assign wr_power = access_done & pwrite & hit_power;
    assign wr_clock = access_done & pwrite & hit_clock;

    // read mux
    logic [31:0] rd_value;
    logic [3:0] power_word;
    assign power_word = {user_flag_one, user_flag_zero, sleep_request_bit, idle_request_bit};
    assign rd_value = hit_power ? {28'h0000000, power_word} :
                      hit_clock ? {31'h00000000, clock_halving_mode} :
                      hit_status ? {27'h0000000, ram_block, mode} : 32'h00000000;

    // apb answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~addr_mapped;
            prdata <= (setup_phase & ~pwrite) ? rd_value : 32'h00000000;
        end
    end

    // user flags are untouched by mode changes and by the reset pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_flag_zero <= pcm_pkg::PCM_RST_POWER_CONTROL[pcm_pkg::PCM_BIT_USER_FLAG_ZERO];
            user_flag_one <= pcm_pkg::PCM_RST_POWER_CONTROL[pcm_pkg::PCM_BIT_USER_FLAG_ONE];
        end else if (wr_power) begin
            user_flag_zero <= pwdata[pcm_pkg::PCM_BIT_USER_FLAG_ZERO];
            user_flag_one <= pwdata[pcm_pkg::PCM_BIT_USER_FLAG_ONE];
        end
    end

    // clock halving select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_halving_mode <= pcm_pkg::PCM_RST_CLOCK_HALVING;
        end else if (wr_clock) begin
            clock_halving_mode <= pwdata[pcm_pkg::PCM_BIT_CLOCK_HALVING];
        end
    end

    // mode sequencing and request bit updates
    always_comb begin
        next_mode = mode;
        next_idle_request_bit = idle_request_bit;
        next_sleep_request_bit = sleep_request_bit;
        if (wr_power) begin
            next_idle_request_bit = pwdata[pcm_pkg::PCM_BIT_IDLE_REQUEST];
            next_sleep_request_bit = pwdata[pcm_pkg::PCM_BIT_SLEEP_REQUEST];
        end
        case (mode)
            pcm_pkg::PCM_RUN: begin
                if (instr_done && sleep_request_bit) begin
                    next_mode = pcm_pkg::PCM_SLEEP;
                    next_idle_request_bit = 1'b0;
                end else if (instr_done && idle_request_bit) begin
                    next_mode = pcm_pkg::PCM_IDLE;
                end
            end
            pcm_pkg::PCM_IDLE: begin
                if (irq_pending) begin
                    next_mode = pcm_pkg::PCM_RUN;
                    next_idle_request_bit = 1'b0;
                end
            end
            pcm_pkg::PCM_SLEEP: begin
                if (ext_wake) begin
                    next_mode = pcm_pkg::PCM_HOLD;
                    next_sleep_request_bit = 1'b0;
                end
            end
            pcm_pkg::PCM_HOLD: begin
                if (!ext_level_low) begin
                    next_mode = pcm_pkg::PCM_RUN;
                end
            end
            default: begin
                next_mode = pcm_pkg::PCM_RUN;
            end
        endcase
    end

    // mode and request bits, cleared at once by the reset pin
    always_ff @(posedge pclk or negedge req_rst_n) begin
        if (!req_rst_n) begin
            mode <= pcm_pkg::PCM_RUN;
            idle_request_bit <= pcm_pkg::PCM_RST_POWER_CONTROL[pcm_pkg::PCM_BIT_IDLE_REQUEST];
            sleep_request_bit <= pcm_pkg::PCM_RST_POWER_CONTROL[pcm_pkg::PCM_BIT_SLEEP_REQUEST];
        end else begin
            mode <= next_mode;
            idle_request_bit <= next_idle_request_bit;
            sleep_request_bit <= next_sleep_request_bit;
        end
    end

    // clock enables follow the next mode so they change with it
    logic next_cpu_clk_en;
    logic next_periph_clk_en;
    logic next_osc_enable;
    assign next_cpu_clk_en = (next_mode == pcm_pkg::PCM_RUN);
    assign next_periph_clk_en = (next_mode != pcm_pkg::PCM_SLEEP);
    assign next_osc_enable = (next_mode != pcm_pkg::PCM_SLEEP);

    // gating flops, forced running by the reset pin
    always_ff @(posedge pclk or negedge req_rst_n) begin
        if (!req_rst_n) begin
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_enable <= 1'b1;
            cpu_hold <= 1'b0;
        end else begin
            cpu_clk_en <= next_cpu_clk_en;
            periph_clk_en <= next_periph_clk_en;
            osc_enable <= next_osc_enable;
            cpu_hold <= ~next_cpu_clk_en;
        end
    end

    // track a low-power stay so a reset pin wake can be recognised
    // kept through the async jump to run, cleared by a clocked wake or once the synced pin is seen
    logic lowpower_move;
    assign lowpower_move = (mode != pcm_pkg::PCM_RUN) | (next_mode != pcm_pkg::PCM_RUN);
    assign next_lowpower_seen = rst_pin_s ? 1'b0 :
                                lowpower_move ? (next_mode != pcm_pkg::PCM_RUN) : lowpower_seen;
    // ram block: set on reset wake, cleared once internal reset runs, set wins
    assign next_ram_block = (rst_pin_s & lowpower_seen) | (ram_block & ~core_reset_active);

    // wake tracking flops on the power-on reset only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowpower_seen <= 1'b0;
            ram_block <= 1'b0;
        end else begin
            lowpower_seen <= next_lowpower_seen;
            ram_block <= next_ram_block;
        end
    end

    // checks on mode entry and exit, register writes and the apb answer
    idle_entry_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_RUN && instr_done && idle_request_bit && !sleep_request_bit)
        |=> (mode == pcm_pkg::PCM_IDLE && !cpu_clk_en))
        else $error("idle not entered after request");

    idle_clocks_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_IDLE) |-> (!cpu_clk_en && periph_clk_en && osc_enable))
        else $error("wrong clock enables in idle");

    state_frozen_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode != pcm_pkg::PCM_RUN) |-> cpu_hold)
        else $error("cpu not held while clock stopped");

    both_bits_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_RUN && instr_done && idle_request_bit && sleep_request_bit)
        |=> (mode == pcm_pkg::PCM_SLEEP && !idle_request_bit))
        else $error("combined request did not pick sleep only");

    idle_wake_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_IDLE && irq_pending)
        |=> (!idle_request_bit && cpu_clk_en && mode == pcm_pkg::PCM_RUN))
        else $error("interrupt did not end idle");

    flags_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_power) |=> ($stable(user_flag_zero) && $stable(user_flag_one)))
        else $error("user flag changed without a write");

    pin_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        reset_pin |-> (!idle_request_bit && !sleep_request_bit && cpu_clk_en && osc_enable))
        else $error("reset pin did not clear requests");

    ram_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rst_pin_s && lowpower_seen) |=> ram_block [*1] ##1 (ram_block || core_reset_active))
        else $error("ram not blocked after reset wake");

    sleep_clocks_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_SLEEP) |-> (!osc_enable && !periph_clk_en && !cpu_clk_en))
        else $error("clocks running in sleep");

    halving_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_clock |=> (clock_halving_mode == $past(pwdata[pcm_pkg::PCM_BIT_CLOCK_HALVING])))
        else $error("clock halving select not stored");

    sleep_wake_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_SLEEP && ext_wake)
        |=> (!sleep_request_bit && osc_enable && periph_clk_en && !cpu_clk_en))
        else $error("external interrupt did not end sleep");

    hold_release_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_HOLD && ext_level_low) |=> !cpu_clk_en)
        else $error("cpu resumed before pin release");

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle wide");

    sleep_entry_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_RUN && instr_done && sleep_request_bit)
        |=> (mode == pcm_pkg::PCM_SLEEP && !osc_enable && !periph_clk_en && !cpu_clk_en))
        else $error("sleep not entered after request");

    sleep_stays_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_SLEEP && !ext_wake) |=> (mode == pcm_pkg::PCM_SLEEP && cpu_hold && !osc_enable))
        else $error("sleep left without a wake");

    idle_stays_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_IDLE && !irq_pending) |=> (mode == pcm_pkg::PCM_IDLE && !cpu_clk_en))
        else $error("idle left without an interrupt");

    hold_exit_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (mode == pcm_pkg::PCM_HOLD && !ext_level_low) |=> (mode == pcm_pkg::PCM_RUN && cpu_clk_en))
        else $error("cpu not resumed after pin release");

    pin_wakes_a: assert property (@(posedge pclk) disable iff (!presetn)
        reset_pin |-> (mode == pcm_pkg::PCM_RUN && periph_clk_en && !cpu_hold))
        else $error("reset pin did not restore clocks");

    ram_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ram_block && core_reset_active && !(rst_pin_s && lowpower_seen)) |=> !ram_block)
        else $error("ram block not released by internal reset");

    power_write_a: assert property (@(posedge pclk) disable iff (!req_rst_n)
        (wr_power && mode == pcm_pkg::PCM_RUN && !instr_done)
        |=> (idle_request_bit == $past(pwdata[pcm_pkg::PCM_BIT_IDLE_REQUEST])
             && sleep_request_bit == $past(pwdata[pcm_pkg::PCM_BIT_SLEEP_REQUEST])))
        else $error("request bits not stored");

    flag_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_power |=> (user_flag_zero == $past(pwdata[pcm_pkg::PCM_BIT_USER_FLAG_ZERO])
             && user_flag_one == $past(pwdata[pcm_pkg::PCM_BIT_USER_FLAG_ONE])))
        else $error("user flags not stored");

    apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pready && !addr_mapped) |=> (pready && pslverr && prdata == 32'h00000000))
        else $error("unmapped address not refused");

endmodule

//--- verif/test_cpu_power_mode_control.sv
// Purpose: self-checking bench for the cpu power mode control block
// Assumes: apb slave answers with one access cycle, pins pass a two-flop synchroniser
// Notes: bench drives every input by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_cpu_power_mode_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic instr_done = 1'b0;
    logic irq_pending = 1'b0;
    logic ext_irq_zero_n = 1'b1;
    logic ext_irq_one_n = 1'b1;
    logic ext_irq_zero_en = 1'b0;
    logic ext_irq_one_en = 1'b0;
    logic reset_pin = 1'b0;
    logic core_reset_active = 1'b0;
    logic cpu_clk_en, periph_clk_en, osc_enable, cpu_hold, clock_halving_mode, ram_block;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rdat;
    logic rerr;

    pcm_power_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_done(instr_done), .irq_pending(irq_pending), .ext_irq_zero_n(ext_irq_zero_n),
        .ext_irq_one_n(ext_irq_one_n), .ext_irq_zero_en(ext_irq_zero_en), .ext_irq_one_en(ext_irq_one_en),
        .reset_pin(reset_pin), .core_reset_active(core_reset_active), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_enable(osc_enable), .cpu_hold(cpu_hold),
        .clock_halving_mode(clock_halving_mode), .ram_block(ram_block));

    // 250 MHz clock
    always #2 pclk = ~pclk;

    // cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdat)
        `CHK("pslverr", ee, rerr)
    endtask

    // one instruction completes, then let its edge land
    task automatic finish_instr();
        @(posedge pclk);
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
        #1;
    endtask

    // wait up to n settled cycles for a level
    task automatic wait_lvl(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) begin
            @(posedge pclk);
            #1;
        end
    endtask

    // pulse the reset pin, check instant wake and the ram block handover
    task automatic reset_wake();
        @(posedge pclk);
        reset_pin <= 1'b1;
        #1;
        `CHK("cpu_clk_en async", 1'b1, cpu_clk_en)
        `CHK("osc_enable async", 1'b1, osc_enable)
        wait_lvl(ram_block, 1'b1, 10);
        `CHK("ram_block set", 1'b1, ram_block)
        @(posedge pclk);
        reset_pin <= 1'b0;
        core_reset_active <= 1'b1;
        wait_lvl(ram_block, 1'b0, 10);
        `CHK("ram_block clear", 1'b0, ram_block)
        @(posedge pclk);
        core_reset_active <= 1'b0;
        rd_chk(pcm_pkg::PCM_OFS_POWER_CONTROL, 32'h0, 1'b0, "requests after reset pin");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and register map
        `CHK("cpu_clk_en reset", 1'b1, cpu_clk_en)
        rd_chk(pcm_pkg::PCM_OFS_POWER_CONTROL, 32'h0, 1'b0, "power control reset");
        rd_chk(pcm_pkg::PCM_OFS_CLOCK_CONFIG, 32'h0, 1'b0, "clock config reset");
        rd_chk(pcm_pkg::PCM_OFS_STATUS, 32'(pcm_pkg::PCM_RUN), 1'b0, "status reset");
        apb(1'b1, pcm_pkg::PCM_OFS_POWER_CONTROL, 32'hC);
        rd_chk(pcm_pkg::PCM_OFS_POWER_CONTROL, 32'hC, 1'b0, "user flags");
        apb(1'b1, 8'h0C, 32'hF);
        `CHK("unmapped write err", 1'b1, rerr)
        rd_chk(8'h0C, 32'h0, 1'b1, "unmapped read");
        apb(1'b1, pcm_pkg::PCM_OFS_STATUS, 32'hF);
        rd_chk(pcm_pkg::PCM_OFS_STATUS, 32'(pcm_pkg::PCM_RUN), 1'b0, "status read only");
        $display("test registers done");
        // clock halving on and off
        for (int v = 1; v >= 0; v--) begin
            apb(1'b1, pcm_pkg::PCM_OFS_CLOCK_CONFIG, 32'(v));
            #1;
            `CHK("clock_halving_mode", 1'(v), clock_halving_mode)
        end
        $display("test clock halving done");
        // idle entry and interrupt wake, flags survive
        apb(1'b1, pcm_pkg::PCM_OFS_POWER_CONTROL, 32'hD);
        #1;
        `CHK("cpu runs before instr end", 1'b1, cpu_clk_en)
        finish_instr();
        `CHK("idle cpu_clk_en", 1'b0, cpu_clk_en)
        `CHK("idle cpu_hold", 1'b1, cpu_hold)
        `CHK("idle periph_clk_en", 1'b1, periph_clk_en)
        `CHK("idle osc_enable", 1'b1, osc_enable)
        repeat (5) @(posedge pclk);
        #1;
        `CHK("idle stays", 1'b0, cpu_clk_en)
        @(posedge pclk);
        irq_pending <= 1'b1;
        @(posedge pclk);
        irq_pending <= 1'b0;
        #1;
        `CHK("wake cpu_clk_en", 1'b1, cpu_clk_en)
        `CHK("wake cpu_hold", 1'b0, cpu_hold)
        rd_chk(pcm_pkg::PCM_OFS_POWER_CONTROL, 32'hC, 1'b0, "idle bit cleared, flags kept");
        $display("test idle done");
        // both request bits together, wake through each pin in turn
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, pcm_pkg::PCM_OFS_POWER_CONTROL, 32'h3);
            finish_instr();
            `CHK("sleep osc_enable", 1'b0, osc_enable)
            `CHK("sleep periph_clk_en", 1'b0, periph_clk_en)
            `CHK("sleep cpu_clk_en", 1'b0, cpu_clk_en)
            `CHK("sleep cpu_hold", 1'b1, cpu_hold)
            @(posedge pclk);
            ext_irq_zero_en <= (p == 0);
            ext_irq_one_en <= (p == 1);
            if (p == 0) ext_irq_zero_n <= 1'b0;
            else ext_irq_one_n <= 1'b0;
            wait_lvl(osc_enable, 1'b1, 10);
            `CHK("pin wake osc_enable", 1'b1, osc_enable)
            `CHK("pin wake periph_clk_en", 1'b1, periph_clk_en)
            repeat (6) @(posedge pclk);
            #1;
            `CHK("cpu held while pin low", 1'b0, cpu_clk_en)
            @(posedge pclk);
            ext_irq_zero_n <= 1'b1;
            ext_irq_one_n <= 1'b1;
            wait_lvl(cpu_clk_en, 1'b1, 10);
            `CHK("cpu resumes", 1'b1, cpu_clk_en)
            rd_chk(pcm_pkg::PCM_OFS_POWER_CONTROL, 32'h0, 1'b0, "both bits cleared");
            rd_chk(pcm_pkg::PCM_OFS_STATUS, 32'(pcm_pkg::PCM_RUN), 1'b0, "no idle after sleep");
        end
        $display("test sleep pin wake done");
        // disabled pin must not wake sleep, reset pin does
        apb(1'b1, pcm_pkg::PCM_OFS_POWER_CONTROL, 32'h2);
        finish_instr();
        @(posedge pclk);
        ext_irq_zero_en <= 1'b0;
        ext_irq_one_en <= 1'b0;
        ext_irq_zero_n <= 1'b0;
        ext_irq_one_n <= 1'b0;
        repeat (8) @(posedge pclk);
        #1;
        `CHK("disabled pin no wake", 1'b0, osc_enable)
        @(posedge pclk);
        ext_irq_zero_n <= 1'b1;
        ext_irq_one_n <= 1'b1;
        repeat (4) @(posedge pclk);
        reset_wake();
        $display("test sleep reset wake done");
        // reset pin ends idle
        apb(1'b1, pcm_pkg::PCM_OFS_POWER_CONTROL, 32'h1);
        finish_instr();
        `CHK("idle before reset pin", 1'b0, cpu_clk_en)
        repeat (4) @(posedge pclk);
        reset_wake();
        $display("test idle reset wake done");
        print_verdict();
    end
endmodule
